//--- mie_pkg.sv
// package of constants and types for the instruction execution subset
package mie_pkg;
    // data and address widths
    localparam int DATA_W = 8;
    localparam int INSTR_W = 14;
    localparam int FILE_AW = 7;
    localparam int BRANCH_W = 11;
    localparam int PC_W = 15;
    localparam int LATCH_W = 7;
    // field positions inside the instruction word and the upper address latch
    localparam int DEST_BIT = 7;
    localparam int LATCH_LO = 3;
    localparam int LATCH_HI = 6;
    // opcode match masks and values
    localparam logic [13:0] CLEAR_WORKING_INSTR_MASK = 14'h3F80;
    localparam logic [13:0] CLEAR_WORKING_INSTR_CODE = 14'h0100;
    localparam logic [13:0] FILE_MASK = 14'h3F00;
    localparam logic [13:0] DECSKIP_CODE = 14'h0B00;
    localparam logic [13:0] INCSKIP_CODE = 14'h0F00;
    localparam logic [13:0] INCREMENT_FILE_INSTR_CODE = 14'h0A00;
    localparam logic [13:0] ORF_CODE = 14'h0400;
    localparam logic [13:0] BRANCH_MASK = 14'h3800;
    localparam logic [13:0] BRANCH_CODE = 14'h2800;
    localparam logic [13:0] ORL_MASK = 14'h3F00;
    localparam logic [13:0] ORL_CODE = 14'h3800;
    // reset values and data constants
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [14:0] PC_RESET = 15'h0000;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [7:0] DATA_ONE = 8'h01;
    // decoded operation classes, one-hot
    typedef enum logic [7:0] {
        OP_NONE = 8'h01,
        OP_CLEAR_WORKING_INSTR = 8'h02,
        OP_DECSKIP = 8'h04,
        OP_INCSKIP = 8'h08,
        OP_BRANCH = 8'h10,
        OP_ORL = 8'h20,
        OP_INCREMENT_FILE_INSTR = 8'h40,
        OP_ORF = 8'h80
    } mie_op_type;
endpackage : mie_pkg

//--- mie_alu.sv
// combinational datapath: result, zero test and flag effect per operation
`timescale 1ns/1ns
module mie_alu
    import mie_pkg::*;
(
    // operation and operands
    input wire mie_op_type op_in,
    input wire logic [7:0] w_in,
    input wire logic [7:0] file_in,
    input wire logic [7:0] literal_in,
    // results
    output logic [7:0] result_out,
    output logic result_zero_out,
    output logic sets_zero_out
);

    // result per operation and whether the zero flag is touched
    always_comb
    begin
        result_out = DATA_ZERO;
        sets_zero_out = 1'b0;
        unique case (op_in)
            OP_NONE:
            begin
                result_out = DATA_ZERO;
            end
            OP_CLEAR_WORKING_INSTR:
            begin
                result_out = DATA_ZERO; // RL1
                sets_zero_out = 1'b1; // RL1
            end
            OP_DECSKIP:
            begin
                result_out = file_in - DATA_ONE; // RL2
            end
            OP_INCSKIP:
            begin
                result_out = file_in + DATA_ONE; // RL4
            end
            OP_BRANCH:
            begin
                result_out = DATA_ZERO;
            end
            OP_ORL:
            begin
                result_out = w_in | literal_in; // RL7
                sets_zero_out = 1'b1; // RL7
            end
            OP_INCREMENT_FILE_INSTR:
            begin
                result_out = file_in + DATA_ONE; // RL8
                sets_zero_out = 1'b1; // RL8
            end
            OP_ORF:
            begin
                result_out = w_in | file_in; // RL9
                sets_zero_out = 1'b1; // RL9
            end
        endcase
    end

    // zero test on the full 8-bit result
    assign result_zero_out = (result_out == DATA_ZERO); // RL10

endmodule : mie_alu

//--- mie_exec.sv
// instruction execution core for the clear, increment, decrement, or and branch subset
// Summary of operation
// RL1: the clear-working instruction loads zero into the working register and sets the zero flag.
// RL2: decrement-and-skip subtracts one from the addressed file register and touches no flag.
// RL3: a zero decrement-and-skip result turns the next fetched instruction into a no-operation.
// RL4: increment-and-skip adds one without flags and on zero discards the next instruction.
// RL5: destination bit 0 sends the result to the working register, 1 back to the file register.
// RL6: the branch loads its 11-bit literal into pc 10..0 and latch bits 6..3 into pc 14..11.
// RL7: or-with-literal ors the working register with the 8-bit literal into the working register.
// RL8: plain increment adds one to the file register, writes the destination and updates zero.
// RL9: or-with-file ors the working register with the file register into the destination.
// RL10: the zero flag follows a zero result where affected and stays unchanged elsewhere.
`timescale 1ns/1ns
module mie_exec
    import mie_pkg::*;
#(
    parameter int PC_WIDTH = PC_W,
    parameter int DATA_WIDTH = DATA_W
)
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // fetched instruction from program memory
    input wire logic [13:0] instr_in,
    input wire logic instr_valid_in,
    // upper program address latch
    input wire logic [6:0] pc_upper_latch_in,
    // file register read data for the address given last cycle
    input wire logic [7:0] file_rdata_in,
    // program counter to fetch
    output logic [14:0] pc_out,
    // file register access
    output logic [6:0] file_raddr_out,
    output logic [6:0] file_waddr_out,
    output logic [7:0] file_wdata_out,
    output logic file_we_out,
    // core state
    output logic [7:0] w_out,
    output logic zero_flag_out,
    output logic discard_out,
    output logic retire_out
);

    // the datapath is built for these widths only
    if (PC_WIDTH != BRANCH_W + LATCH_HI - LATCH_LO + 1 || DATA_WIDTH != DATA_W)
    begin : g_width_check
        $error("mie_exec: unsupported width parameters");
    end

    // decode stage registers
    logic [13:0] instr_q, instr_d;
    logic valid_q, valid_d;
    logic [6:0] raddr_q, raddr_d;
    // execute state registers
    logic [14:0] pc_q, pc_d;
    logic [7:0] w_q, w_d;
    logic zero_q, zero_d;
    logic [6:0] waddr_q, waddr_d;
    logic [7:0] wdata_q, wdata_d;
    logic we_q, we_d;
    logic discard_q, discard_d;
    logic retire_q, retire_d;

    // decode and datapath wires
    mie_op_type op;
    logic [7:0] file_val;
    logic [7:0] result;
    logic result_zero;
    logic sets_zero;
    logic dest_file;
    logic skip;
    logic branch;
    logic [10:0] branch_target;

    // classify the instruction held in the execute slot
    always_comb
    begin
        op = OP_NONE;
        if (valid_q)
        begin
            if ((instr_q & CLEAR_WORKING_INSTR_MASK) == CLEAR_WORKING_INSTR_CODE)
                op = OP_CLEAR_WORKING_INSTR;
            else if ((instr_q & FILE_MASK) == DECSKIP_CODE)
                op = OP_DECSKIP;
            else if ((instr_q & FILE_MASK) == INCSKIP_CODE)
                op = OP_INCSKIP;
            else if ((instr_q & FILE_MASK) == INCREMENT_FILE_INSTR_CODE)
                op = OP_INCREMENT_FILE_INSTR;
            else if ((instr_q & FILE_MASK) == ORF_CODE)
                op = OP_ORF;
            else if ((instr_q & ORL_MASK) == ORL_CODE)
                op = OP_ORL;
            else if ((instr_q & BRANCH_MASK) == BRANCH_CODE)
                op = OP_BRANCH;
        end
    end

    // forward a file write still in flight to the same address
    assign file_val = (we_q && waddr_q == instr_q[6:0]) ? wdata_q : file_rdata_in;

    // arithmetic and logic for the decoded operation
    mie_alu u_alu (
        .op_in(op),
        .w_in(w_q),
        .file_in(file_val),
        .literal_in(instr_q[7:0]),
        .result_out(result),
        .result_zero_out(result_zero),
        .sets_zero_out(sets_zero)
    );

    assign dest_file = instr_q[DEST_BIT];
    assign branch_target = instr_q[10:0];
    assign branch = (op == OP_BRANCH);
    // a zero result of either skip form discards the next instruction
    assign skip = (op == OP_DECSKIP || op == OP_INCSKIP) && result_zero; // RL3 RL4

    // decode stage: capture the fetched word unless it must be discarded
    always_comb
    begin
        instr_d = instr_in;
        valid_d = instr_valid_in && !(skip || branch); // RL3 RL4 RL6
        raddr_d = instr_in[6:0];
    end

    // decode stage registers
    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            instr_q <= 14'h0000;
            valid_q <= 1'b0;
            raddr_q <= 7'h00;
        end
        else
        begin
            instr_q <= instr_d;
            valid_q <= valid_d;
            raddr_q <= raddr_d;
        end
    end

    // execute stage: working register, flags, file write back and program counter
    always_comb
    begin
        w_d = w_q;
        zero_d = zero_q;
        waddr_d = instr_q[6:0];
        wdata_d = result;
        we_d = 1'b0;
        pc_d = pc_q + 15'h0001;
        discard_d = skip || branch;
        retire_d = valid_q;
        if (sets_zero)
            zero_d = result_zero; // RL10
        unique case (op)
            OP_NONE:
            begin
                w_d = w_q;
            end
            OP_CLEAR_WORKING_INSTR:
            begin
                w_d = result; // RL1
            end
            OP_ORL:
            begin
                w_d = result; // RL7
            end
            OP_BRANCH:
            begin
                pc_d = {pc_upper_latch_in[LATCH_HI:LATCH_LO], branch_target}; // RL6
            end
            OP_DECSKIP, OP_INCSKIP, OP_INCREMENT_FILE_INSTR, OP_ORF:
            begin
                // destination select for file-register forms
                if (dest_file)
                    we_d = 1'b1; // RL5
                else
                    w_d = result; // RL5 RL2 RL8 RL9
            end
        endcase
    end

    // execute stage registers
    always_ff @(posedge mclk_in)
    begin
        if (srst_in)
        begin
            pc_q <= PC_RESET;
            w_q <= W_RESET;
            zero_q <= 1'b0;
            waddr_q <= 7'h00;
            wdata_q <= DATA_ZERO;
            we_q <= 1'b0;
            discard_q <= 1'b0;
            retire_q <= 1'b0;
        end
        else
        begin
            pc_q <= pc_d;
            w_q <= w_d;
            zero_q <= zero_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            we_q <= we_d;
            discard_q <= discard_d;
            retire_q <= retire_d;
        end
    end

    // outputs straight from registers
    assign pc_out = pc_q;
    assign file_raddr_out = raddr_q;
    assign file_waddr_out = waddr_q;
    assign file_wdata_out = wdata_q;
    assign file_we_out = we_q;
    assign w_out = w_q;
    assign zero_flag_out = zero_q;
    assign discard_out = discard_q;
    assign retire_out = retire_q;

endmodule : mie_exec

//--- mie_exec_chk.sv
// checker of results, flags and skips for the instruction execution subset
`timescale 1ns/1ns
module mie_exec_chk
    import mie_pkg::*;
(
    // clock, reset and inputs
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic [13:0] instr_in,
    input wire logic instr_valid_in,
    input wire logic [6:0] pc_upper_latch_in,
    input wire logic [7:0] file_rdata_in,
    // outputs
    input wire logic [14:0] pc_out,
    input wire logic [6:0] file_raddr_out,
    input wire logic [6:0] file_waddr_out,
    input wire logic [7:0] file_wdata_out,
    input wire logic file_we_out,
    input wire logic [7:0] w_out,
    input wire logic zero_flag_out,
    input wire logic discard_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    // file operand as the core sees it: a write still pending to the same address wins
    logic [7:0] opnd;
    assign opnd = (file_we_out && file_waddr_out == file_raddr_out) ?
        file_wdata_out : file_rdata_in;
    // opcode match on one instruction word
    function automatic logic op(logic [13:0] i, logic [13:0] m, logic [13:0] c);
        return (i & m) == c;
    endfunction : op
    // an instruction captured and not dropped by the one before it
    sequence s_take(logic ok);
        instr_valid_in && ok ##1 !discard_out;
    endsequence
    property p_clear_working_instr;
        s_take(op(instr_in, CLEAR_WORKING_INSTR_MASK, CLEAR_WORKING_INSTR_CODE)) |=> w_out == 8'h00 && zero_flag_out;
    endproperty
    a_clear_working_instr: assert property (p_clear_working_instr) else $error("clear working result wrong");
    property p_orl;
        s_take(op(instr_in, ORL_MASK, ORL_CODE)) |=> w_out == ($past(w_out) |
            $past(instr_in[7:0], 2)) && zero_flag_out == (w_out == 8'h00);
    endproperty
    a_orl: assert property (p_orl) else $error("or literal result wrong");
    property p_branch;
        s_take(op(instr_in, BRANCH_MASK, BRANCH_CODE)) |=> discard_out && $stable(zero_flag_out)
            && pc_out == {$past(pc_upper_latch_in[6:3]), $past(instr_in[10:0], 2)};
    endproperty
    a_branch: assert property (p_branch) else $error("branch target wrong");
    property p_dec_zero;
        (s_take(op(instr_in, FILE_MASK, DECSKIP_CODE)) ##0 opnd == 8'h01)
            |=> discard_out && $stable(zero_flag_out);
    endproperty
    a_dec_zero: assert property (p_dec_zero) else $error("decrement skip missed");
    property p_inc_zero;
        (s_take(op(instr_in, FILE_MASK, INCSKIP_CODE)) ##0 opnd == 8'hFF)
            |=> discard_out && $stable(zero_flag_out);
    endproperty
    a_inc_zero: assert property (p_inc_zero) else $error("increment skip missed");
    property p_no_skip;
        (s_take(op(instr_in, FILE_MASK, DECSKIP_CODE)) ##0 opnd != 8'h01)
            |=> !discard_out && $stable(zero_flag_out);
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("skip on nonzero");
    property p_increment_file_instr;
        s_take(op(instr_in, FILE_MASK | 14'h0080, INCREMENT_FILE_INSTR_CODE | 14'h0080)) |=> file_we_out &&
            file_wdata_out == $past(opnd) + 8'h01 &&
            zero_flag_out == (file_wdata_out == 8'h00);
    endproperty
    a_increment_file_instr: assert property (p_increment_file_instr) else $error("increment write back wrong");
    property p_orf_w;
        s_take(op(instr_in, FILE_MASK | 14'h0080, ORF_CODE)) |=> !file_we_out &&
            w_out == ($past(w_out) | $past(opnd));
    endproperty
    a_orf_w: assert property (p_orf_w) else $error("or file to working wrong");
endmodule : mie_exec_chk

//--- mie_exec_bench.sv
// testbench of the instruction execution subset
`timescale 1ns/1ns
module mie_exec_bench
    import mie_pkg::*;
;
    typedef struct packed {
        logic [13:0] ins;
        logic [7:0] w;
        logic z;
        logic we;
        logic [7:0] wd;
    } mie_row_type;
    // stimulus, outputs and file register model
    logic mclk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [13:0] instr_in = 14'h0000;
    logic instr_valid_in = 1'b0;
    logic [6:0] pc_upper_latch_in = 7'h00;
    logic [7:0] file_rdata_in;
    logic [14:0] pc_out;
    logic [6:0] file_raddr_out;
    logic [6:0] file_waddr_out;
    logic [7:0] file_wdata_out;
    logic file_we_out;
    logic [7:0] w_out;
    logic zero_flag_out;
    logic discard_out;
    logic retire_out;
    logic [7:0] mem [128];
    int failures = 0;
    int n_compared = 0;
    mie_row_type rows [12] = '{
        '{14'h38A5, 8'hA5, 1'b0, 1'b0, 8'h00}, '{14'h0100, 8'h00, 1'b1, 1'b0, 8'h00},
        '{14'h3800, 8'h00, 1'b1, 1'b0, 8'h00}, '{14'h0AA5, 8'h00, 1'b1, 1'b1, 8'h00},
        '{14'h383C, 8'h3C, 1'b0, 1'b0, 8'h00}, '{14'h0A10, 8'h02, 1'b0, 1'b0, 8'h00},
        '{14'h0491, 8'h02, 1'b0, 1'b1, 8'hF2}, '{14'h0412, 8'h02, 1'b0, 1'b0, 8'h00},
        '{14'h0100, 8'h00, 1'b1, 1'b0, 8'h00}, '{14'h0B93, 8'h00, 1'b1, 1'b1, 8'h04},
        '{14'h3881, 8'h81, 1'b0, 1'b0, 8'h00}, '{14'h0F14, 8'h01, 1'b0, 1'b0, 8'h00}};
    // clock and file register read and write
    always #50 mclk_in = ~mclk_in;
    assign file_rdata_in = mem[file_raddr_out];
    always @(posedge mclk_in)
        if (file_we_out === 1'b1)
            mem[file_waddr_out] <= file_wdata_out;
    mie_exec dut (.mclk_in, .srst_in, .instr_in, .instr_valid_in, .pc_upper_latch_in,
        .file_rdata_in, .pc_out, .file_raddr_out, .file_waddr_out, .file_wdata_out,
        .file_we_out, .w_out, .zero_flag_out, .discard_out, .retire_out);
    task cmp_out(input logic [14:0] exp, input logic [14:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp_out
    // one instruction then a bubble, results settled at return
    task run_op(input logic [13:0] ins);
        instr_in = ins;
        instr_valid_in = 1'b1;
        @(posedge mclk_in);
        #1;
        instr_valid_in = 1'b0;
        @(posedge mclk_in);
        #1;
    endtask : run_op
    // instruction followed back to back by an or literal that must be dropped
    task kill_op(input logic [13:0] ins, input logic br);
        instr_in = ins;
        instr_valid_in = 1'b1;
        @(posedge mclk_in);
        #1;
        instr_in = 14'h38FF;
        @(posedge mclk_in);
        #1;
        cmp_out(15'h0001, 15'(discard_out));
        if (br)
            cmp_out(15'h5923, pc_out);
        instr_valid_in = 1'b0;
        @(posedge mclk_in);
        #1;
        cmp_out(15'h0000, 15'(retire_out));
        cmp_out(15'h0000, 15'(w_out));
        cmp_out(15'h0000, 15'(zero_flag_out));
    endtask : kill_op
    task do_reset;
        srst_in = 1'b1;
        repeat (2) @(posedge mclk_in);
        #1;
        cmp_out(15'h0000, pc_out);
        cmp_out(15'h0000, {w_out, zero_flag_out, file_we_out, retire_out, discard_out, 3'h0});
        srst_in = 1'b0;
    endtask : do_reset
    task test_done;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    // hang guard
    initial
    begin
        repeat (500) @(posedge mclk_in);
        failures++;
        test_done();
    end
    // main sequence
    initial
    begin
        foreach (mem[i])
            mem[i] = 8'h00;
        mem[7'h25] = 8'hFF;
        mem[7'h10] = 8'h01;
        mem[7'h11] = 8'hF0;
        mem[7'h13] = 8'h05;
        mem[7'h15] = 8'h01;
        mem[7'h16] = 8'hFF;
        do_reset();
        $display("test reset done");
        foreach (rows[i])
        begin
            run_op(rows[i].ins);
            cmp_out(15'(rows[i].w), 15'(w_out));
            cmp_out(15'(rows[i].z), 15'(zero_flag_out));
            cmp_out(15'(rows[i].we), 15'(file_we_out));
            if (rows[i].we)
            begin
                cmp_out(15'(rows[i].wd), 15'(file_wdata_out));
                cmp_out(15'(rows[i].ins[6:0]), 15'(file_waddr_out));
            end
            cmp_out(15'h0001, 15'(retire_out + discard_out));
        end
        $display("test rows done");
        do_reset();
        kill_op(14'h0B15, 1'b0);
        kill_op(14'h0F16, 1'b0);
        $display("test skip done");
        pc_upper_latch_in = 7'h5A;
        kill_op(14'h2923, 1'b1);
        cmp_out(15'h5924, pc_out);
        $display("test branch done");
        // two increments of one file register back to back: the second needs the first's write
        instr_in = 14'h0AB0;
        instr_valid_in = 1'b1;
        @(posedge mclk_in);
        #1;
        @(posedge mclk_in);
        #1;
        instr_valid_in = 1'b0;
        cmp_out(15'h0001, 15'(file_wdata_out));
        @(posedge mclk_in);
        #1;
        cmp_out(15'h0002, 15'(file_wdata_out));
        cmp_out(15'h0001, 15'(file_we_out));
        $display("test forward done");
        test_done();
    end
endmodule : mie_exec_bench
bind mie_exec mie_exec_chk u_chk (.mclk_in, .srst_in, .instr_in, .instr_valid_in,
    .pc_upper_latch_in, .file_rdata_in, .pc_out, .file_raddr_out, .file_waddr_out,
    .file_wdata_out, .file_we_out, .w_out,
    .zero_flag_out, .discard_out);
